/* File: rtcca_regs.sv */
// control register 2, interrupt cycle select and weekly alarm registers
// assumes counters on pclk deliver time_now and a sec_tick pulse with
// the new time, plus a 2048 Hz one-cycle tick; chip_enable is a pin
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module rtcca_regs
  import rtcca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_enable,
  input wire logic tick_2048,
  input wire logic sec_tick,
  input wire rtcca_time_t time_now,
  output logic irq_out_n,
  output logic irq,
  output logic test_mode,
  output logic hour_24h,
  output logic timer_restart
);

  rtcca_apb_t ap_state_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic ce_s1_r, ce_s2_r;
  logic [3:0] ctrl2_r, cyc_r;
  logic [3:0] aw_lo_r, aw_hi_r, am_u_r, am_t_r, ah_u_r, ah_t_r;
  logic alm_flag_r, per_flag_r;
  logic [1:0] status_r, mask_r;
  logic sq_r, half_low_r;
  logic [10:0] half_cnt_r;
  logic irq_out_n_r, irq_r, tmr_pulse_r, test_mode_r;

  logic [5:0] idx;
  logic setup, acc, wr, rd;
  logic [31:0] rd_val;
  logic rd_bad;
  logic [6:0] wday_mask;
  logic alarm_hit, alarm_evt, level_evt;
  logic [7:0] lv_events;
  logic bank1;

  assign idx = paddr[7:2];
  assign setup = clk_en && psel && !penable;
  assign acc = clk_en && psel && penable && (ap_state_r == AP_RESP);
  assign wr = acc && pwrite && !pslverr_r;
  assign rd = acc && !pwrite && !pslverr_r;
  assign bank1 = ctrl2_r[C2_BANK];
  assign wday_mask = {aw_hi_r[2:0], aw_lo_r};

  // apb handshake: no wait states, pready in the first access cycle, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_state_r <= AP_IDLE;
    end else if (clk_en) begin
      case (ap_state_r)
        AP_IDLE: if (psel && !penable) ap_state_r <= AP_RESP;
        AP_RESP: ap_state_r <= AP_IDLE;
        default: ap_state_r <= AP_IDLE;
      endcase
    end
  end

  // read mux; bank bit chooses counters or alarm for the low indices
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_bad = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rd_bad = 1'b1;
    end else if (idx == IDX_PSEL) begin
      rd_val[3:0] = cyc_r;
    end else if (idx == IDX_CTRL1) begin
      rd_val[C1_PER_FLAG] = per_flag_r;
      rd_val[C1_ALM_FLAG] = alm_flag_r;
    end else if (idx == IDX_CTRL2) begin
      rd_val[3:0] = ctrl2_r;
    end else if (idx == IDX_STAT) begin
      rd_val[1:0] = status_r;
    end else if (idx == IDX_MASK) begin
      rd_val[1:0] = mask_r;
    end else if (idx > IDX_CTRL2) begin
      rd_bad = 1'b1;
    end else if (bank1) begin
      if (idx == IDX_AW_LO) begin
        rd_val[3:0] = aw_lo_r;
      end else if (idx == IDX_AW_HI) begin
        rd_val[3:0] = aw_hi_r;
      end else if (idx == IDX_AM_U) begin
        rd_val[3:0] = am_u_r;
      end else if (idx == IDX_AM_T) begin
        rd_val[2:0] = am_t_r[2:0];
      end else if (idx == IDX_AH_U) begin
        rd_val[3:0] = ah_u_r;
      end else if (idx == IDX_AH_T) begin
        rd_val[3] = ah_t_r[3]; // bit 2 unused
        rd_val[1:0] = ah_t_r[1:0];
      end
    end else begin
      // counter view is read only here; the counters own their writes
      if (idx == IDX_AW_LO) begin
        rd_val[3:0] = time_now.second[3:0];
      end else if (idx == IDX_AW_HI) begin
        rd_val[2:0] = time_now.second[6:4];
      end else if (idx == IDX_AM_U) begin
        rd_val[3:0] = time_now.minute[3:0];
      end else if (idx == IDX_AM_T) begin
        rd_val[2:0] = time_now.minute[6:4];
      end else if (idx == IDX_AH_U) begin
        rd_val[3:0] = time_now.hour[3:0];
      end else if (idx == IDX_AH_T) begin
        rd_val[1:0] = time_now.hour[5:4];
      end else if (idx == IDX_WDAY) begin
        rd_val[2:0] = time_now.wday;
      end else if (idx == IDX_DAY_U) begin
        rd_val[3:0] = time_now.mday[3:0];
      end else if (idx == IDX_DAY_T) begin
        rd_val[1:0] = time_now.mday[5:4];
      end
    end
  end

  // capture answer in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= rd_bad;
    end
  end

  // chip enable pin crosses into pclk through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_s1_r <= 1'b0;
      ce_s2_r <= 1'b0;
    end else if (clk_en) begin
      ce_s1_r <= chip_enable;
      ce_s2_r <= ce_s1_r;
    end
  end

  // control register 2; a low chip enable wins over a software write.
  // test_mode has its own flop so the output needs no inverter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_r <= CTRL2_RST;
      test_mode_r <= !CTRL2_RST[C2_TEST];
    end else if (clk_en) begin
      if (wr && idx == IDX_CTRL2) ctrl2_r <= pwdata[3:0];
      if (!ce_s2_r) ctrl2_r[C2_TEST] <= 1'b1;
      if (!ce_s2_r) begin
        test_mode_r <= 1'b0;
      end else if (wr && idx == IDX_CTRL2) begin
        test_mode_r <= !pwdata[C2_TEST];
      end
    end
  end

  // timer restart strobe to the timer counter on each write of 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_pulse_r <= 1'b0;
    end else if (clk_en) begin
      tmr_pulse_r <= wr && idx == IDX_CTRL2 && pwdata[C2_TMR];
    end
  end

  // cycle select and alarm nibbles; unused bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= NIBBLE_RST;
      aw_lo_r <= NIBBLE_RST;
      aw_hi_r <= NIBBLE_RST;
      am_u_r <= NIBBLE_RST;
      am_t_r <= NIBBLE_RST;
      ah_u_r <= NIBBLE_RST;
      ah_t_r <= NIBBLE_RST;
    end else if (wr) begin
      if (idx == IDX_PSEL) cyc_r <= pwdata[3:0];
      if (bank1) begin
        if (idx == IDX_AW_LO) aw_lo_r <= pwdata[3:0];
        if (idx == IDX_AW_HI) aw_hi_r <= pwdata[3:0];
        if (idx == IDX_AM_U) am_u_r <= pwdata[3:0];
        if (idx == IDX_AM_T) am_t_r <= {1'b0, pwdata[2:0]};
        if (idx == IDX_AH_U) ah_u_r <= pwdata[3:0];
        if (idx == IDX_AH_T) begin
          ah_t_r <= {pwdata[3], 1'b0, pwdata[1:0]};
        end
      end
    end
  end

  // alarm compare at second 00; hour digits compare as stored, so the
  // pm flag or hour-twenty bit follows the selected format on both sides
  assign alarm_hit = sec_tick && (time_now.second == 8'h00) &&
    wday_mask[time_now.wday] &&
    (time_now.minute == {1'b0, am_t_r[2:0], am_u_r}) &&
    (time_now.hour == {2'b00, ah_t_r[1:0], ah_u_r});
  assign alarm_evt = alarm_hit && ah_t_r[AH_T_ENABLE];

  // level-mode events, decoded from the freshly updated time
  always_comb begin
    lv_events[0] = sec_tick;
    lv_events[1] = lv_events[0] && time_now.second[3:0] == 4'h0;
    lv_events[2] = lv_events[0] && time_now.second == 8'h00;
    lv_events[3] = lv_events[2] && time_now.minute[3:0] == 4'h0;
    lv_events[4] = lv_events[2] && time_now.minute == 8'h00;
    lv_events[5] = lv_events[4] && (ctrl2_r[C2_H24] ?
      time_now.hour == HOUR_MIDNIGHT_24 :
      time_now.hour == HOUR_MIDNIGHT_12);
    lv_events[6] = lv_events[5] && time_now.wday == 3'h0;
    lv_events[7] = lv_events[5] && time_now.mday == MDAY_FIRST;
  end
  assign level_evt = cyc_r[3] && lv_events[cyc_r[2:0]];

  // flags in control register 1; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_flag_r <= 1'b0;
      per_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (alarm_evt) begin
        alm_flag_r <= 1'b1;
      end else if (wr && idx == IDX_CTRL1 && !pwdata[C1_ALM_FLAG]) begin
        alm_flag_r <= 1'b0;
      end
      if (!cyc_r[3]) begin
        per_flag_r <= 1'b0; // flag has no meaning in pulse mode
      end else if (level_evt) begin
        per_flag_r <= 1'b1;
      end else if (wr && idx == IDX_CTRL1) begin
        per_flag_r <= pwdata[C1_PER_FLAG];
      end
    end
  end

  // pulse-mode waves from the 2048 Hz tick: square wave toggles on every
  // tick, the half-second pulse is low for one tick per period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_r <= 1'b0;
      half_cnt_r <= 11'h000;
      half_low_r <= 1'b0;
    end else if (clk_en && tick_2048) begin
      sq_r <= !sq_r;
      if (half_cnt_r == HALF_SEC_TICKS - 11'h001) begin
        half_cnt_r <= 11'h000;
        half_low_r <= 1'b1;
      end else begin
        half_cnt_r <= half_cnt_r + 11'h001;
        half_low_r <= 1'b0;
      end
    end
  end

  // sticky status, cleared by reading it; set wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= EVT_RST;
      mask_r <= EVT_RST;
    end else if (clk_en) begin
      status_r <= ((rd && idx == IDX_STAT) ? EVT_RST : status_r) |
        {level_evt, alarm_evt};
      if (wr && idx == IDX_MASK) mask_r <= pwdata[1:0];
    end
  end

  // interrupt pin, active low; alarm gated by its mask bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_n_r <= 1'b1;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      irq_out_n_r <= !((alm_flag_r && !aw_hi_r[AW_HI_IRQ_MASK]) ||
        (cyc_r[3] && per_flag_r) ||
        (!cyc_r[3] && cyc_r[1:0] == PM_LOW) ||
        (!cyc_r[3] && cyc_r[1:0] == PM_SQUARE && sq_r) ||
        (!cyc_r[3] && cyc_r[1:0] == PM_HALF && half_low_r));
      irq_r <= |(status_r & mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = ap_state_r[1];
  assign pslverr = pslverr_r;
  assign irq_out_n = irq_out_n_r;
  assign irq = irq_r;
  assign test_mode = test_mode_r;
  assign hour_24h = ctrl2_r[C2_H24];
  assign timer_restart = tmr_pulse_r;

  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_ctrl2_tmr_wr;
    wr && idx == IDX_CTRL2 && pwdata[C2_TMR];
  endsequence
  // level event, then an enabled edge with level mode still selected
  sequence s_level_hold;
    (clk_en && level_evt) ##1 (clk_en && cyc_r[3]);
  endsequence

  a_ce_forces_test: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !ce_s2_r |=> !test_mode)
    else $error("test bit not forced while chip enable low");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup and (ap_state_r == AP_IDLE) |=> pready)
    else $error("pready missing after setup");
  a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_unused_reads: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup and (!pwrite && bank1 && paddr == {IDX_AM_T, 2'h0})
    |=> prdata[31:3] == 29'h0)
    else $error("unused alarm bits read nonzero");
  a_no_weekday: assert property (@(posedge pclk) disable iff (!presetn)
    wday_mask == 7'h00 |-> !alarm_evt)
    else $error("alarm fired with no weekday enabled");
  a_alarm_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && alarm_hit && ah_t_r[AH_T_ENABLE] |=> alm_flag_r)
    else $error("alarm match did not set the flag");
  a_alarm_pin: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && alm_flag_r && !aw_hi_r[AW_HI_IRQ_MASK] |=> !irq_out_n)
    else $error("unmasked alarm did not pull the pin");
  a_level_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && level_evt |=> per_flag_r)
    else $error("level event did not set the periodic flag");
  // the pin follows one edge behind the flag while level mode stays on
  a_level_pin: assert property (@(posedge pclk) disable iff (!presetn)
    s_level_hold |=> !irq_out_n)
    else $error("periodic flag did not pull the pin");
  a_pulse_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !cyc_r[3] |=> !per_flag_r)
    else $error("periodic flag set in pulse mode");
  // a masked alarm with the pulse output off must leave the pin high
  a_alarm_masked: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && aw_hi_r[AW_HI_IRQ_MASK] && !cyc_r[3] &&
    cyc_r[1:0] == PM_OFF |=> irq_out_n)
    else $error("masked alarm drove the pin");
  // the strobe is judged only when the edge after the write is enabled
  a_restart_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl2_tmr_wr ##1 clk_en |-> timer_restart ##1 !timer_restart)
    else $error("timer restart strobe wrong");

endmodule

/* File: rtcca_pkg.sv */
// constants, field layout and carrier types of the rtc control/alarm block
// assumes an apb master and a counter block on the same pclk
package rtcca_pkg;

  // register index; byte address is four times the index
  localparam logic [5:0] IDX_AW_LO = 6'h00;
  localparam logic [5:0] IDX_AW_HI = 6'h01;
  localparam logic [5:0] IDX_AM_U = 6'h02;
  localparam logic [5:0] IDX_AM_T = 6'h03;
  localparam logic [5:0] IDX_AH_U = 6'h04;
  localparam logic [5:0] IDX_AH_T = 6'h05;
  localparam logic [5:0] IDX_WDAY = 6'h06;
  localparam logic [5:0] IDX_PSEL = 6'h07;
  localparam logic [5:0] IDX_DAY_U = 6'h08;
  localparam logic [5:0] IDX_DAY_T = 6'h09;
  localparam logic [5:0] IDX_CTRL1 = 6'h0E;
  localparam logic [5:0] IDX_CTRL2 = 6'h0F;
  localparam logic [5:0] IDX_STAT = 6'h10;
  localparam logic [5:0] IDX_MASK = 6'h11;

  // field positions
  localparam int C2_TEST = 0;
  localparam int C2_BANK = 1;
  localparam int C2_TMR = 2;
  localparam int C2_H24 = 3;
  localparam int AW_HI_IRQ_MASK = 3;
  localparam int AH_T_ENABLE = 3;
  localparam int C1_PER_FLAG = 0;
  localparam int C1_ALM_FLAG = 1;
  localparam int ST_ALARM = 0;
  localparam int ST_PERIODIC = 1;

  // values after reset
  localparam logic [3:0] CTRL2_RST = 4'h1;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [1:0] EVT_RST = 2'h0;

  // pulse-mode codes (low two bits of the cycle field)
  localparam logic [1:0] PM_OFF = 2'h0;
  localparam logic [1:0] PM_LOW = 2'h1;
  localparam logic [1:0] PM_SQUARE = 2'h2;
  localparam logic [1:0] PM_HALF = 2'h3;

  // timebase: 2048 Hz tick, 0.5 s half-second period in ticks
  localparam int TICK_HZ = 2048;
  localparam int HALF_SEC_MS = 500;
  localparam logic [10:0] HALF_SEC_TICKS =
    11'(TICK_HZ * HALF_SEC_MS / 1000);

  // bcd values of interest
  localparam logic [7:0] HOUR_MIDNIGHT_24 = 8'h00;
  localparam logic [7:0] HOUR_MIDNIGHT_12 = 8'h12;
  localparam logic [7:0] MDAY_FIRST = 8'h01;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_RESP = 2'b10
  } rtcca_apb_t;

  // current time from the counters, bcd
  typedef struct packed {
    logic [7:0] mday;
    logic [2:0] wday;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtcca_time_t;

endpackage

/* File: rtcca_time_src.sv */
// far-side model: time counters and timebase feeding the register block
// assumes one pclk; the testbench asks for each new second by set_req
`timescale 1ns/1ns
module rtcca_time_src
  import rtcca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_req,
  input wire rtcca_time_t set_val,
  output logic tick_2048,
  output logic sec_tick,
  output rtcca_time_t time_now
);
  logic [1:0] div_r;
  // tick every 4 cycles: keeps square-wave runs short, not real rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      tick_2048 <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      tick_2048 <= (div_r == 2'h3);
    end
  end
  // new second already shows on time_now while sec_tick is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_now <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= set_req;
      if (set_req) time_now <= set_val;
    end
  end
endmodule

/* File: rtc_control_alarm_regs_tb.sv */
// self-checking bench for the rtc control and alarm registers
// assumes rtcca_regs and the rtcca_time_src counter model
`timescale 1ns/1ns
module rtc_control_alarm_regs_tb;
  import rtcca_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic chip_enable = 1'b1, set_req = 1'b0;
  rtcca_time_t set_val = '0;
  rtcca_time_t time_now;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq_out_n, irq, test_mode, hour_24h, err;
  logic timer_restart, tick_2048, sec_tick;
  logic [7:0] h = 8'h00, m = 8'h00;
  logic [6:0] wm;
  logic [2:0] w = 3'h0;
  // the counter model ticks every 4 pclk
  localparam int TICK_CYC = 4;
  logic [3:0] d;
  logic msk, en, ex;
  int mismatches = 0, total_checks = 0, seed = 32'ha7f1, c, k, n;

  rtcca_regs i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .chip_enable,
    .tick_2048, .sec_tick, .time_now, .irq_out_n, .irq, .test_mode,
    .hour_24h, .timer_restart);
  rtcca_time_src i_src (.pclk, .presetn, .set_req, .set_val,
    .tick_2048, .sec_tick, .time_now);

  always #5 pclk = ~pclk;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one apb transfer; pready and read data are taken at a rising edge,
  // and one idle edge after it lets the effect of a write show
  task automatic apb(logic wr, logic [5:0] idx, logic [31:0] wd);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 40) chk("pready", 0, 1);
  endtask
  task automatic wr(logic [5:0] idx, logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  // the counters show a new second, then let flags and the pin settle
  task automatic step(logic [7:0] s);
    set_val <= {MDAY_FIRST, w, h, m, s};
    set_req <= 1'b1;
    @(posedge pclk);
    set_req <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic [3:0] wmask(int i);
    return (i == 3) ? 4'h7 : (i == 5) ? 4'hB : 4'hF;
  endfunction
  function automatic logic hit(logic [6:0] wk, logic [2:0] wd, logic e);
    return e && wk[wd];
  endfunction
  // level-mode expectation at minute 00, hour 00 (24h), weekday 1, day 01
  function automatic logic lv_hit(int cd, logic [7:0] s);
    return (cd == 0) || (cd == 1 && s[3:0] == 4'h0) ||
      (cd > 1 && cd != 6 && s == 8'h00);
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_CTRL2, 0);
    chk("ctrl2 reset", rd, 32'(CTRL2_RST));
    wr(IDX_CTRL2, 32'h0);
    chk("test mode", test_mode, 1);
    chip_enable <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("test forced", test_mode, 0);
    apb(1'b0, IDX_CTRL2, 0);
    chk("ctrl2 test bit", rd[0], 1);
    chip_enable <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wr(IDX_CTRL2, {28'h0, 1'b1, k[0], 2'b11});
      chk("restart", timer_restart, k);
      chk("hour 24", hour_24h, 1);
      @(posedge pclk);
      chk("restart end", timer_restart, 0);
    end
    $display("control test done");
    // random fill of the alarm bank, unused bits must read back zero
    repeat (3) for (k = 0; k < 6; k++) begin
      d = 4'($random(seed));
      wr(6'(k), {28'h0, d});
      apb(1'b0, 6'(k), 0);
      chk("alarm reg", rd, {28'h0, d & wmask(k)});
    end
    wr(IDX_PSEL, 32'h6);
    wr(IDX_CTRL2, 32'h9);
    apb(1'b0, IDX_PSEL, 0);
    chk("cycle sel bank0", rd, 6);
    m = 8'h47;
    step(8'h05);
    wr(IDX_AM_U, 32'h3);
    apb(1'b0, IDX_AM_U, 0);
    chk("bank0 minute", rd, 7);
    apb(1'b0, 6'h12, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    $display("map test done");
    wr(IDX_PSEL, 32'h0);
    wr(IDX_MASK, 32'h1);
    for (c = 0; c < 6; c++) begin
      w = 3'($unsigned($random(seed)) % 7);
      m = {1'b0, 3'($unsigned($random(seed)) % 6),
        4'($unsigned($random(seed)) % 10)};
      h = (c == 1) ? 8'h32 : 8'h23;
      msk = (c == 2);
      en = (c != 3);
      wm = (c == 4) ? ~(7'h1 << w) : (c == 5) ? 7'h0 : 7'h1 << w;
      ex = hit(wm, w, en);
      wr(IDX_CTRL2, {28'h0, c != 1, 3'b011});
      wr(IDX_AW_LO, {28'h0, wm[3:0]});
      wr(IDX_AW_HI, {28'h0, msk, wm[6:4]});
      wr(IDX_AM_U, {28'h0, m[3:0]});
      wr(IDX_AM_T, {28'h0, m[7:4]});
      wr(IDX_AH_U, {28'h0, h[3:0]});
      wr(IDX_AH_T, {28'h0, en, 1'b0, h[5:4]});
      step(8'h00);
      chk("irq", irq, ex);
      chk("pin", irq_out_n, !(ex && !msk));
      apb(1'b0, IDX_CTRL1, 0);
      chk("alarm flag", rd[1], ex);
      apb(1'b0, IDX_STAT, 0);
      chk("status", rd[0], ex);
      wr(IDX_CTRL1, 32'h0);
      repeat (3) @(posedge pclk);
      chk("pin clear", irq_out_n, 1);
      chk("irq clear", irq, 0);
    end
    $display("alarm test done");
    wr(IDX_PSEL, 32'h8);
    step(8'h07);
    chk("level pin", irq_out_n, 0);
    chk("masked irq", irq, 0);
    apb(1'b0, IDX_CTRL1, 0);
    chk("periodic flag", rd[0], 1);
    wr(IDX_CTRL1, 32'h0);
    repeat (2) @(posedge pclk);
    chk("level release", irq_out_n, 1);
    // every level code, once at second 10 and once at second 00
    h = 8'h00;
    m = 8'h00;
    w = 3'h1;
    for (c = 0; c < 8; c++) begin
      wr(IDX_PSEL, 32'(8 + c));
      for (k = 0; k < 2; k++) begin
        step(k[0] ? 8'h00 : 8'h10);
        apb(1'b0, IDX_CTRL1, 0);
        chk("level code", rd[0], lv_hit(c, k[0] ? 8'h00 : 8'h10));
        wr(IDX_CTRL1, 32'h0);
      end
    end
    wr(IDX_PSEL, {30'h0, PM_LOW});
    repeat (3) @(posedge pclk);
    chk("pin held low", irq_out_n, 0);
    wr(IDX_PSEL, {30'h0, PM_OFF});
    wr(IDX_CTRL1, 32'h1);
    apb(1'b0, IDX_CTRL1, 0);
    chk("pulse flag", rd[0], 0);
    chk("pin off", irq_out_n, 1);
    wr(IDX_PSEL, {30'h0, PM_SQUARE});
    n = 0;
    ex = irq_out_n;
    repeat (32) begin
      @(negedge pclk);
      if (irq_out_n !== ex) n++;
      ex = irq_out_n;
    end
    chk("square toggles", n >= 7 && n <= 9, 1);
    // one full half-second period holds exactly one tick of low pin
    wr(IDX_PSEL, {30'h0, PM_HALF});
    n = 0;
    repeat (TICK_CYC * HALF_SEC_TICKS) begin
      @(negedge pclk);
      if (irq_out_n === 1'b0) n++;
    end
    chk("half second low", n, TICK_CYC);
    $display("periodic test done");
    close_out();
  end
endmodule
